/* hw/set_ones_pkg.sv */
package set_ones_pkg;

    // Instruction word layout
    localparam int          INSTR_W      = 16;
    localparam int          OFFSET_W     = 8;
    localparam int          ADDR_W       = 12;
    localparam int          DATA_W       = 8;
    localparam logic [7:0]  OPCODE_HI    = 8'h68;   // 0110 1000
    localparam logic [7:0]  OFFSET_MAX   = 8'h5F;   // 95
    localparam logic [7:0]  FILL_VALUE   = 8'hFF;
    localparam logic [4:0]  STATUS_RST   = 5'h00;
    localparam logic [ADDR_W-1:0] PTR_RST = 12'h000;

    // Quarter phase enumeration
    typedef enum logic [1:0] {
        PH_Q1,
        PH_Q2,
        PH_Q3,
        PH_Q4
    } phase_e;

    // Data memory write request
    typedef struct packed {
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } mem_wr_s;

endpackage : set_ones_pkg

/* hw/quarter_phase_gen.sv */
`timescale 1ns/1ps
`default_nettype none

// Four-phase sequencer; each clock is one quarter of an instruction cycle
module quarter_phase_gen
    import set_ones_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Phase output
    output phase_e    phase
);

    typedef struct packed {
        phase_e ph;
    } qp_state_s;

    qp_state_s st_q;
    qp_state_s st_d;

    // Advance phase every clock, wrapping Q4 to Q1
    always_comb begin
        st_d = st_q;
        unique case (st_q.ph)
            PH_Q1: st_d.ph = PH_Q2;
            PH_Q2: st_d.ph = PH_Q3;
            PH_Q3: st_d.ph = PH_Q4;
            PH_Q4: st_d.ph = PH_Q1;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '{ph: PH_Q1};
        end else begin
            st_q <= st_d;
        end
    end

    assign phase = st_q.ph;

endmodule : quarter_phase_gen
`default_nettype wire

/* hw/set_byte_all_ones.sv */
`timescale 1ns/1ps
`default_nettype none

module set_byte_all_ones
    import set_ones_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Instruction fetch
    input  wire logic              instr_valid,
    input  wire logic [INSTR_W-1:0] instr_word,
    // Core state
    input  wire logic [ADDR_W-1:0] indirect_pointer_two,
    input  wire logic [4:0]        status_in,
    // Data memory write
    output mem_wr_s                mem_wr,
    // Status and results
    output logic [4:0]             status_out,
    output logic                   instr_done,
    output logic                   offset_fault
);

    typedef struct packed {
        logic              hit;
        logic [7:0]        offset;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        mem_wr_s           wr;
        logic [4:0]        status;
        logic              done;
        logic              fault;
    } core_state_s;

    core_state_s st_q;
    core_state_s st_d;
    phase_e      phase;

    // Zero-extend the offset, then add to pointer
    function automatic logic [ADDR_W-1:0] target_addr(input logic [ADDR_W-1:0] ptr,
                                                     input logic [7:0]        k);
        target_addr = ptr + {{(ADDR_W-8){1'b0}}, k};
    endfunction : target_addr

    // Opcode match on the upper byte of a program word
    function automatic logic is_set_ones(input logic [INSTR_W-1:0] w);
        is_set_ones = (w[15:8] == OPCODE_HI);
    endfunction : is_set_ones

    // Offset inside the accepted literal range
    function automatic logic offset_ok(input logic [7:0] k);
        offset_ok = (k <= OFFSET_MAX);
    endfunction : offset_ok

    quarter_phase_gen u_phase (
        .clk   (clk),
        .rst_n (rst_n),
        .phase (phase)
    );

    // One instruction per four-phase cycle
    always_comb begin
        st_d      = st_q;
        st_d.done = 1'b0;
        st_d.wr.we = 1'b0;
        st_d.status = status_in;
        unique case (phase)
            PH_Q1: begin
                // Decode the single program word
                st_d.hit   = instr_valid && is_set_ones(instr_word);
                st_d.fault = 1'b0;
            end
            PH_Q2: begin
                st_d.offset = instr_word[7:0];
                if (st_q.hit && !offset_ok(instr_word[7:0])) begin
                    st_d.hit   = 1'b0;
                    st_d.fault = 1'b1;
                end
            end
            PH_Q3: begin
                st_d.addr = target_addr(indirect_pointer_two, st_q.offset);
                st_d.data = FILL_VALUE;
            end
            PH_Q4: begin
                st_d.wr.we   = st_q.hit;
                st_d.wr.addr = st_q.addr;
                st_d.wr.data = st_q.data;
                st_d.done    = st_q.hit;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '{hit: 1'b0, offset: 8'h00, addr: PTR_RST, data: 8'h00,
                      wr: '{we: 1'b0, addr: PTR_RST, data: 8'h00},
                      status: STATUS_RST, done: 1'b0, fault: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign mem_wr       = st_q.wr;
    assign status_out   = st_q.status;
    assign instr_done   = st_q.done;
    assign offset_fault = st_q.fault;

    // Steps of one instruction slot, used by the properties below
    // Decode edge with a matching opcode
    sequence s_decode_hit;
        phase == PH_Q1 && instr_valid && is_set_ones(instr_word);
    endsequence

    // Offset edge with an accepted literal
    sequence s_offset_good;
        phase == PH_Q2 && offset_ok(instr_word[7:0]);
    endsequence

    // Offset edge with a refused literal
    sequence s_offset_bad;
        phase == PH_Q2 && !offset_ok(instr_word[7:0]);
    endsequence

    // Write data is all ones
    a_write_all_ones: assert property (
        @(posedge clk) disable iff (!rst_n)
        mem_wr.we |-> mem_wr.data == FILL_VALUE)
        else $error("write data not all ones");

    // Flags pass through one cycle later
    a_status_held: assert property (
        @(posedge clk) disable iff (!rst_n)
        status_out == $past(status_in))
        else $error("status changed");

    // At most one write per instruction slot
    a_write_once_cycle: assert property (
        @(posedge clk) disable iff (!rst_n)
        mem_wr.we |=> !mem_wr.we [*3])
        else $error("more than one write per cycle");

    // Write strobe launched only from Q4
    a_write_in_q4: assert property (
        @(posedge clk) disable iff (!rst_n)
        mem_wr.we |-> $past(phase) == PH_Q4)
        else $error("write outside Q4");

    // Refused offset never reaches memory
    a_range_refused: assert property (
        @(posedge clk) disable iff (!rst_n)
        (phase == PH_Q2 && st_q.hit && !offset_ok(instr_word[7:0])) |-> ##3 !mem_wr.we)
        else $error("out-of-range offset written");

    // Address is pointer plus zero-extended offset
    a_addr_sum: assert property (
        @(posedge clk) disable iff (!rst_n)
        (phase == PH_Q3 && st_q.hit) |=> st_q.addr == $past(indirect_pointer_two)
            + {4'h0, $past(st_q.offset)})
        else $error("target address wrong");

    // Matching opcode is taken at the decode edge
    a_decode_opcode: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_decode_hit |=> st_q.hit)
        else $error("opcode not recognised");

    // Offset captured at the Q2 edge
    a_offset_in_q2: assert property (
        @(posedge clk) disable iff (!rst_n)
        (phase == PH_Q2) |=> st_q.offset == $past(instr_word[7:0]))
        else $error("offset not read in Q2");

    // Accepted instruction writes at the slot end
    a_full_write: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_decode_hit ##1 s_offset_good |-> ##3 (mem_wr.we && instr_done
            && mem_wr.addr == $past(indirect_pointer_two, 2)
            + {4'h0, $past(instr_word[7:0], 3)}))
        else $error("accepted instruction not written");

    // Refused offset raises the fault and skips the write
    a_fault_raised: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_decode_hit ##1 s_offset_bad |=> offset_fault ##2 !mem_wr.we)
        else $error("refused offset not flagged");

    // Fault and write never stand together
    a_fault_no_write: assert property (
        @(posedge clk) disable iff (!rst_n)
        offset_fault |-> !mem_wr.we)
        else $error("write while fault stands");

    // Fault drops at each decode edge
    a_fault_cleared: assert property (
        @(posedge clk) disable iff (!rst_n)
        (phase == PH_Q1) |=> !offset_fault)
        else $error("fault not cleared");

    // Other words are ignored
    a_miss_ignored: assert property (
        @(posedge clk) disable iff (!rst_n)
        (phase == PH_Q1 && !(instr_valid && is_set_ones(instr_word)))
            |=> !st_q.hit ##3 !mem_wr.we)
        else $error("foreign word executed");

    // Done pulse tracks the write strobe
    a_done_with_write: assert property (
        @(posedge clk) disable iff (!rst_n)
        instr_done == mem_wr.we)
        else $error("done without write");

    // Four phases make one instruction cycle
    a_phase_wrap: assert property (
        @(posedge clk) disable iff (!rst_n)
        (phase == PH_Q4) |=> (phase == PH_Q1))
        else $error("phase did not wrap");

    // Fill value staged at the Q3 edge
    a_data_prepared: assert property (
        @(posedge clk) disable iff (!rst_n)
        (phase == PH_Q3) |=> st_q.data == FILL_VALUE)
        else $error("fill value not staged");

    // Write address moves only at the Q4 edge
    a_addr_stable: assert property (
        @(posedge clk) disable iff (!rst_n)
        (phase != PH_Q1) |-> $stable(mem_wr.addr))
        else $error("write address moved");

endmodule : set_byte_all_ones
`default_nettype wire

/* bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench import set_ones_pkg::*; ;
    logic               clk;
    logic               rst_n;
    logic               instr_valid;
    logic [INSTR_W-1:0] instr_word;
    logic [ADDR_W-1:0]  indirect_pointer_two;
    logic [4:0]         status_in;
    logic [4:0]         prev_status;
    mem_wr_s            mem_wr;
    logic [4:0]         status_out;
    logic               instr_done;
    logic               offset_fault;
    int                 fail_count = 0;
    int                 total_checks = 0;
    int                 cycles = 0;
    logic [31:0]        seed = 32'd53575;
    logic [31:0]        r;
    logic [ADDR_W-1:0]  exp_q[$];
    logic [7:0]         kt[5] = '{8'h00, 8'h5F, 8'h60, 8'hFF, 8'h2C};

    set_byte_all_ones DUT (.clk, .rst_n, .instr_valid, .instr_word, .indirect_pointer_two,
        .status_in, .mem_wr, .status_out, .instr_done, .offset_fault);

    // Free-running core clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done();
        $display("Checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done

    // One instruction slot of four quarter phases
    task automatic run(input logic v, input logic [7:0] op, input logic [7:0] k,
                       input logic [ADDR_W-1:0] p);
        instr_valid = v;
        instr_word = {op, k};
        indirect_pointer_two = p;
        status_in = 5'(rnd());
        if (v && op === OPCODE_HI && k <= OFFSET_MAX)
            exp_q.push_back(p + {4'h0, k});
        repeat (3) @(posedge clk);
        #1 check(offset_fault, v && op === OPCODE_HI && k > OFFSET_MAX);
        @(posedge clk);
        #1 check(exp_q.size() <= 1, 1'b1);
    endtask : run

    // Write monitor, flag pass-through and hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles > 1000) begin
            fail_count++;
            test_done();
        end
        if (rst_n) begin
            check(status_out, prev_status);
            check(instr_done, mem_wr.we);
            if (mem_wr.we === 1'b1) begin
                check(exp_q.size() > 0, 1'b1);
                if (exp_q.size() > 0)
                    check({mem_wr.addr, mem_wr.data}, {exp_q.pop_front(), FILL_VALUE});
            end
        end
        prev_status = rst_n ? status_in : 5'h00;
    end

    // Main sequence
    initial begin
        rst_n = 1'b0;
        instr_valid = 1'b0;
        instr_word = '0;
        indirect_pointer_two = '0;
        status_in = '0;
        prev_status = '0;
        repeat (20) @(posedge clk);
        #1 rst_n = 1'b1;
        foreach (kt[i]) run(1'b1, OPCODE_HI, kt[i], 12'hFA0);
        $display("Test boundary offsets done");
        for (int i = 0; i < 60; i++) begin
            r = rnd();
            run(r[0] | r[1], r[2] ? OPCODE_HI : r[15:8], r[3] ? r[23:16] % 8'h60 : r[23:16],
                r[31:20]);
        end
        $display("Test random stream done");
        instr_valid = 1'b0;
        repeat (8) @(posedge clk);
        #1 check(exp_q.size(), 24'h000000);
        test_done();
    end
endmodule : testbench

`default_nettype wire
